// file: design/usb_status_pins.sv
// Top: activity indicators, D+ pull-up gate, reset pin and two status outputs
//
// Decided for this implementation: the address map and the address-and-strobe port.
`timescale 1ns/1ps
module usb_status_pins (
    // Clock and reset
    input  wire logic       CLK,
    input  wire logic       RST_N,
    // Register port
    input  wire logic [3:0] ADDR,
    input  wire logic [7:0] WDATA,
    input  wire logic       WR,
    input  wire logic       RD,
    output logic [7:0]      RDATA,
    // UART activity
    input  wire logic       TX_BUSY,
    input  wire logic       RX_BUSY,
    // USB state from the protocol engine
    input  wire logic       USB_BUS_RESET,
    input  wire logic       USB_SUSPENDED,
    input  wire logic       USB_CONFIGURED,
    input  wire logic       BUS_POWER_SENSE_IN,
    // Shared activity pins, four signals each
    input  wire logic       CHAN_A_TX_ACTIVITY_PIN_I,
    output logic            CHAN_A_TX_ACTIVITY_PIN_O,
    output logic            CHAN_A_TX_ACTIVITY_PIN_OE,
    output logic            CHAN_A_TX_ACTIVITY_PIN_PU,
    input  wire logic       CHAN_A_RX_ACTIVITY_PIN_I,
    output logic            CHAN_A_RX_ACTIVITY_PIN_O,
    output logic            CHAN_A_RX_ACTIVITY_PIN_OE,
    output logic            CHAN_A_RX_ACTIVITY_PIN_PU,
    // D+ pull-up enable
    output logic            DPLUS_PULLUP_EN,
    // Open-drain reset pin
    input  wire logic       RESET_PIN_N_I,
    output logic            RESET_PIN_N_O,
    output logic            RESET_PIN_N_OE,
    output logic            CORE_RESET,
    // Status outputs
    output logic            USB_CONDITION_OUT_ONE,
    output logic            USB_CONDITION_OUT_TWO
);
    // Software registers
    logic [7:0] pin_func_r;                    // Activity pin function
    logic [7:0] condition_out_one_config_r;    // Output one select and polarity
    logic [7:0] condition_out_two_config_r;    // Output two select and polarity
    logic [7:0] max_power_r;                   // Declared maximum power
    logic [7:0] control_r;                     // Pull-up request
    logic [7:0] rdata_r;                       // Read data
    // Reset pin logic
    logic [7:0] rst_cnt_r;                     // Drive-low counter
    logic [7:0] ext_cnt_r;                     // External low-time counter
    logic       ext_rst_r;                     // External reset accepted
    logic       bus_rst_d_r;                   // Bus reset, delayed for edge
    // Pin output flops
    logic       tx_o_r, rx_o_r, tx_oe_r, rx_oe_r;
    logic       dp_r, one_r, two_r, rpin_oe_r, core_rst_r;

    // Decode
    wire wr_func  = WR && (ADDR == status_pins_pkg::PIN_FUNC_ADDR);
    wire wr_one   = WR && (ADDR == status_pins_pkg::COND_ONE_ADDR);
    wire wr_two   = WR && (ADDR == status_pins_pkg::COND_TWO_ADDR);
    wire wr_pwr   = WR && (ADDR == status_pins_pkg::MAX_POWER_ADDR);
    wire wr_ctrl  = WR && (ADDR == status_pins_pkg::CONTROL_ADDR);
    // Software reset strobe is self-clearing; it is never stored
    wire sw_rst   = wr_ctrl && WDATA[status_pins_pkg::CTRL_SWRST_BIT];
    wire bus_rst_rise = USB_BUS_RESET && !bus_rst_d_r;
    wire ext_long = (ext_cnt_r >= 8'(status_pins_pkg::EXT_RST_MIN_CYC - 1));
    // Pull-up request gated by bus power
    wire pullup_ok = BUS_POWER_SENSE_IN && control_r[status_pins_pkg::CTRL_PULLUP_BIT];

    // Condition evaluator shared by both outputs
    function automatic logic cond_eval(input logic [7:0] cfg, input logic rst,
                                       input logic susp, input logic cfgd,
                                       input logic [7:0] pwr);
        logic unsafe;
        logic hit;
        unsafe = susp || ((pwr > status_pins_pkg::UNIT_LOAD_MAX) && !cfgd);
        hit = (cfg[status_pins_pkg::COND_RESET_BIT] && rst)
            || (cfg[status_pins_pkg::COND_SUSP_BIT] && susp)
            || (cfg[status_pins_pkg::COND_POWER_BIT] && unsafe);
        // No hit gives the inactive level
        return hit ? cfg[status_pins_pkg::COND_POL_BIT]
                   : ~cfg[status_pins_pkg::COND_POL_BIT];
    endfunction : cond_eval

    wire tx_blink;
    wire rx_blink;
    wire tx_sel = pin_func_r[status_pins_pkg::FUNC_TX_BIT];
    wire rx_sel = pin_func_r[status_pins_pkg::FUNC_RX_BIT];

    activity_blinker u_tx (
        .clk   (CLK),
        .rst_n (RST_N),
        .busy  (TX_BUSY),
        .level (tx_blink)
    );
    activity_blinker u_rx (
        .clk   (CLK),
        .rst_n (RST_N),
        .busy  (RX_BUSY),
        .level (rx_blink)
    );

    // Register writes; reset values make the pins GPIO inputs with pull-up
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            pin_func_r                 <= status_pins_pkg::PIN_FUNC_RST;
            condition_out_one_config_r <= status_pins_pkg::COND_ONE_RST;
            condition_out_two_config_r <= status_pins_pkg::COND_TWO_RST;
            max_power_r                <= status_pins_pkg::MAX_POWER_RST;
            control_r                  <= status_pins_pkg::CONTROL_RST;
        end else begin
            if (wr_func) pin_func_r <= WDATA;
            if (wr_one)  condition_out_one_config_r <= WDATA;
            if (wr_two)  condition_out_two_config_r <= WDATA;
            if (wr_pwr)  max_power_r <= WDATA;
            if (wr_ctrl) control_r <= {6'h00, WDATA[status_pins_pkg::CTRL_PULLUP_BIT], 1'b0};
        end
    end

    // Read data valid the cycle after the strobe only
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            rdata_r <= 8'h00;
        end else if (!RD) begin
            rdata_r <= 8'h00;
        end else begin
            case (ADDR)
                status_pins_pkg::PIN_FUNC_ADDR:  rdata_r <= pin_func_r;
                status_pins_pkg::COND_ONE_ADDR:  rdata_r <= condition_out_one_config_r;
                status_pins_pkg::COND_TWO_ADDR:  rdata_r <= condition_out_two_config_r;
                status_pins_pkg::MAX_POWER_ADDR: rdata_r <= max_power_r;
                status_pins_pkg::CONTROL_ADDR:   rdata_r <= control_r;
                status_pins_pkg::STATUS_ADDR:    rdata_r <= {1'b0, CHAN_A_RX_ACTIVITY_PIN_I,
                    CHAN_A_TX_ACTIVITY_PIN_I, RESET_PIN_N_I, dp_r, two_r, one_r, core_rst_r};
                default:                         rdata_r <= 8'h00;
            endcase
        end
    end

    // Reset pin: external low must last the minimum before it counts
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            ext_cnt_r <= 8'h00;
            ext_rst_r <= 1'b0;
        end else if (RESET_PIN_N_I || rpin_oe_r) begin
            // Our own drive is not mistaken for an external request
            ext_cnt_r <= 8'h00;
            ext_rst_r <= 1'b0;
        end else if (ext_long) begin
            ext_rst_r <= 1'b1;
        end else begin
            ext_cnt_r <= ext_cnt_r + 8'h01;
        end
    end

    // Drive the pin low at power-on and on register or bus reset
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            rst_cnt_r   <= 8'(status_pins_pkg::RST_OUT_CYC);
            bus_rst_d_r <= 1'b0;
            rpin_oe_r   <= 1'b1;
            core_rst_r  <= 1'b1;
        end else begin
            bus_rst_d_r <= USB_BUS_RESET;
            if (sw_rst || bus_rst_rise) begin
                rst_cnt_r <= 8'(status_pins_pkg::RST_OUT_CYC);
            end else if (rst_cnt_r != 8'h00) begin
                rst_cnt_r <= rst_cnt_r - 8'h01;
            end
            rpin_oe_r  <= sw_rst || bus_rst_rise || (rst_cnt_r > 8'h01);
            core_rst_r <= sw_rst || bus_rst_rise || (rst_cnt_r > 8'h01) || ext_rst_r;
        end
    end

    // Pin outputs, all from flops
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            tx_o_r  <= 1'b0;
            rx_o_r  <= 1'b0;
            tx_oe_r <= 1'b0;
            rx_oe_r <= 1'b0;
            dp_r    <= 1'b0;
            one_r   <= 1'b0;   // Inactive for active-high default
            two_r   <= 1'b1;   // Inactive for active-low default
        end else begin
            tx_o_r  <= tx_blink;
            rx_o_r  <= rx_blink;
            tx_oe_r <= tx_sel;
            rx_oe_r <= rx_sel;
            // Pull-up only with bus power present
            dp_r    <= pullup_ok;
            one_r   <= cond_eval(condition_out_one_config_r, USB_BUS_RESET, USB_SUSPENDED,
                                 USB_CONFIGURED, max_power_r);
            two_r   <= cond_eval(condition_out_two_config_r, USB_BUS_RESET, USB_SUSPENDED,
                                 USB_CONFIGURED, max_power_r);
        end
    end

    assign CHAN_A_TX_ACTIVITY_PIN_O  = tx_o_r;
    assign CHAN_A_RX_ACTIVITY_PIN_O  = rx_o_r;
    assign CHAN_A_TX_ACTIVITY_PIN_OE = tx_oe_r;
    assign CHAN_A_RX_ACTIVITY_PIN_OE = rx_oe_r;
    assign CHAN_A_TX_ACTIVITY_PIN_PU = pin_func_r[status_pins_pkg::FUNC_PU_BIT];
    assign CHAN_A_RX_ACTIVITY_PIN_PU = pin_func_r[status_pins_pkg::FUNC_PU_BIT];
    assign DPLUS_PULLUP_EN           = dp_r;
    assign RESET_PIN_N_O             = 1'b0;
    assign RESET_PIN_N_OE            = rpin_oe_r;
    assign CORE_RESET                = core_rst_r;
    assign USB_CONDITION_OUT_ONE     = one_r;
    assign USB_CONDITION_OUT_TWO     = two_r;
    assign RDATA                     = rdata_r;
endmodule : usb_status_pins

// file: design/status_pins_pkg.sv
// Shared constants for the USB status, reset and activity indicator pin logic
package status_pins_pkg;
    // Clock rate and indicator timing
    localparam int unsigned CLK_HZ          = 10000000;
    localparam int unsigned BLINK_HZ        = 10;
    // Half period of a 10 Hz toggle, in cycles
    localparam int unsigned BLINK_HALF_CYC  = CLK_HZ / (BLINK_HZ * 2);
    // Least external reset pulse, in ns, and the cycle count (rounded up)
    localparam int unsigned EXT_RST_MIN_NS  = 15000;
    localparam int unsigned CLK_PERIOD_NS   = 100;
    localparam int unsigned EXT_RST_MIN_CYC = (EXT_RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Internal reset pulse length driven onto the reset pin
    localparam int unsigned RST_OUT_CYC     = EXT_RST_MIN_CYC;
    // Unit-load threshold of the declared maximum power
    localparam logic [7:0]  UNIT_LOAD_MAX   = 8'h32;

    // Register map
    localparam logic [3:0]  PIN_FUNC_ADDR   = 4'h0;
    localparam logic [3:0]  COND_ONE_ADDR   = 4'h1;
    localparam logic [3:0]  COND_TWO_ADDR   = 4'h2;
    localparam logic [3:0]  MAX_POWER_ADDR  = 4'h3;
    localparam logic [3:0]  CONTROL_ADDR    = 4'h4;
    localparam logic [3:0]  STATUS_ADDR     = 4'h5;

    // Pin function bits
    localparam int unsigned FUNC_TX_BIT     = 0;
    localparam int unsigned FUNC_RX_BIT     = 1;
    localparam int unsigned FUNC_PU_BIT     = 2;
    localparam logic [7:0]  PIN_FUNC_RST    = 8'h04;

    // Condition config bits: select mask and polarity
    localparam int unsigned COND_RESET_BIT  = 0;
    localparam int unsigned COND_SUSP_BIT   = 1;
    localparam int unsigned COND_POWER_BIT  = 2;
    localparam int unsigned COND_POL_BIT    = 7;
    localparam logic [7:0]  COND_ONE_RST    = 8'h82;
    localparam logic [7:0]  COND_TWO_RST    = 8'h02;
    localparam logic [7:0]  MAX_POWER_RST   = 8'h32;

    // Control bits
    localparam int unsigned CTRL_SWRST_BIT  = 0;
    localparam int unsigned CTRL_PULLUP_BIT = 1;
    localparam logic [7:0]  CONTROL_RST     = 8'h00;
endpackage : status_pins_pkg

// file: design/activity_blinker.sv
// One activity indicator: toggles at 10 Hz while its UART is busy
`timescale 1ns/1ps
module activity_blinker (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Activity in, toggle level out
    input  wire logic busy,
    output logic      level
);
    logic [19:0] count_r;   // Half-period counter
    logic        level_r;   // Toggle level
    logic        wrap;      // Half period reached

    assign wrap  = (count_r == 20'(status_pins_pkg::BLINK_HALF_CYC - 1));
    assign level = level_r;

    // Count only while busy; idle parks the pin high, matching the pull-up
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_r <= 20'h00000;
            level_r <= 1'b1;
        end else if (!busy) begin
            count_r <= 20'h00000;
            level_r <= 1'b1;
        end else if (wrap) begin
            count_r <= 20'h00000;
            level_r <= ~level_r;
        end else begin
            count_r <= count_r + 20'h00001;
        end
    end
endmodule : activity_blinker

// file: sim/usb_status_pins_monitor.sv
// Checker of the status, reset and indicator pin behaviour
`timescale 1ns/1ps
module usb_status_pins_monitor (
    // Clock, reset, register writes
    input wire logic       CLK,
    input wire logic       RST_N,
    input wire logic [3:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic       WR,
    // Causes
    input wire logic       TX_BUSY,
    input wire logic       RX_BUSY,
    input wire logic       USB_BUS_RESET,
    input wire logic       USB_SUSPENDED,
    input wire logic       USB_CONFIGURED,
    input wire logic       BUS_POWER_SENSE_IN,
    // Effects
    input wire logic       CHAN_A_TX_ACTIVITY_PIN_O,
    input wire logic       CHAN_A_TX_ACTIVITY_PIN_OE,
    input wire logic       CHAN_A_TX_ACTIVITY_PIN_PU,
    input wire logic       CHAN_A_RX_ACTIVITY_PIN_O,
    input wire logic       CHAN_A_RX_ACTIVITY_PIN_OE,
    input wire logic       CHAN_A_RX_ACTIVITY_PIN_PU,
    input wire logic       DPLUS_PULLUP_EN,
    input wire logic       RESET_PIN_N_O,
    input wire logic       RESET_PIN_N_OE,
    input wire logic       USB_CONDITION_OUT_ONE,
    input wire logic       USB_CONDITION_OUT_TWO
);
    logic [7:0] f_r, c1_r, c2_r, p_r; // Config mirrors
    // Mirror writes so expected levels need no peek inside
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            f_r <= 8'h04;
            c1_r <= 8'h82;
            c2_r <= 8'h02;
            p_r <= 8'h32;
        end else if (WR) begin
            if (ADDR == 4'h0) f_r <= WDATA;
            if (ADDR == 4'h1) c1_r <= WDATA;
            if (ADDR == 4'h2) c2_r <= WDATA;
            if (ADDR == 4'h3) p_r <= WDATA;
        end
    end
    // Unsafe: suspended, or high power and not configured
    wire u = USB_SUSPENDED | ((p_r > 8'h32) & !USB_CONFIGURED);
    wire [2:0] hit = {u, USB_SUSPENDED, USB_BUS_RESET};
    // A hit gives the active level, none the inverse
    wire e1 = |(c1_r[2:0] & hit) ? c1_r[7] : !c1_r[7];
    wire e2 = |(c2_r[2:0] & hit) ? c2_r[7] : !c2_r[7];
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);
    property p_od; RESET_PIN_N_O == 1'b0; endproperty
    a_od: assert property (p_od) else $error("reset pin drives high");
    property p_por; $rose(RST_N) |-> RESET_PIN_N_OE [*8]; endproperty
    a_por: assert property (p_por) else $error("reset pin not held");
    property p_brst; $rose(USB_BUS_RESET) |-> ##[1:2] RESET_PIN_N_OE; endproperty
    a_brst: assert property (p_brst) else $error("bus reset not driven");
    property p_dp; !BUS_POWER_SENSE_IN |=> !DPLUS_PULLUP_EN; endproperty
    a_dp: assert property (p_dp) else $error("pull-up on without power");
    property p_one; USB_CONDITION_OUT_ONE == $past(e1); endproperty
    a_one: assert property (p_one) else $error("output one wrong");
    property p_two; USB_CONDITION_OUT_TWO == $past(e2); endproperty
    a_two: assert property (p_two) else $error("output two wrong");
    property p_txi; (!TX_BUSY) [*3] |-> CHAN_A_TX_ACTIVITY_PIN_O; endproperty
    a_txi: assert property (p_txi) else $error("tx idle level");
    property p_rxi; (!RX_BUSY) [*3] |-> CHAN_A_RX_ACTIVITY_PIN_O; endproperty
    a_rxi: assert property (p_rxi) else $error("rx idle level");
    property p_fn;
        {CHAN_A_TX_ACTIVITY_PIN_OE, CHAN_A_RX_ACTIVITY_PIN_OE} == $past(f_r[1:0])
        && CHAN_A_TX_ACTIVITY_PIN_PU == f_r[2];
    endproperty
    a_fn: assert property (p_fn) else $error("pin function wrong");
endmodule : usb_status_pins_monitor
bind usb_status_pins usb_status_pins_monitor monitor_inst (.*);

// file: sim/board_model.sv
// Board model: pulled-up reset line, supervisor pulse, indicator pads
`timescale 1ns/1ps
module board_model (
    // Clock and supervisor command
    input wire logic        clk,
    input wire logic        go,
    input wire logic [15:0] plen,
    // Device pin controls
    input wire logic        rst_oe,
    input wire logic        tx_o,
    input wire logic        tx_oe,
    input wire logic        tx_pu,
    input wire logic        rx_o,
    input wire logic        rx_oe,
    input wire logic        rx_pu,
    // Resolved pad levels
    output logic            rst_pin,
    output logic            tx_pad,
    output logic            rx_pad
);
    int   low_cnt = 0;     // Supervisor cycles left
    logic flip_r  = 1'b0;  // Floating pad wanders
    // Supervisor holds the line low for the commanded span
    always @(posedge clk) begin
        flip_r <= !flip_r;
        if (go) low_cnt <= plen;
        else if (low_cnt > 0) low_cnt <= low_cnt - 1;
    end
    // Open drain with pull-up; undriven pad without pull-up is not trusted
    assign rst_pin = !(rst_oe || low_cnt > 0);
    assign tx_pad = tx_oe ? tx_o : (tx_pu | flip_r);
    assign rx_pad = rx_oe ? rx_o : (rx_pu | flip_r);
endmodule : board_model

// file: sim/usb_status_pins_test.sv
// Self-checking bench for the status, reset and indicator pin block
`timescale 1ns/1ps
module usb_status_pins_test;
    logic clk, rst_n, wr, rd, txb, rxb, brst, susp, cfgd, vsen, go;
    logic [3:0] addr;
    logic [7:0] wdata, rdata;
    logic [15:0] plen;
    logic txo, txoe, txpu, rxo, rxoe, rxpu, dpl, rpoe, core, one, two, rpin, txp, rxp;
    int n_mismatch = 0;
    int checks = 0;
    logic [7:0] rv [0:4] = '{8'h04, 8'h82, 8'h02, 8'h32, 8'h00}; // Reset values
    usb_status_pins usb_status_pins_inst (.CLK(clk), .RST_N(rst_n), .ADDR(addr),
        .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .TX_BUSY(txb), .RX_BUSY(rxb),
        .USB_BUS_RESET(brst), .USB_SUSPENDED(susp), .USB_CONFIGURED(cfgd),
        .BUS_POWER_SENSE_IN(vsen), .CHAN_A_TX_ACTIVITY_PIN_I(txp),
        .CHAN_A_TX_ACTIVITY_PIN_O(txo), .CHAN_A_TX_ACTIVITY_PIN_OE(txoe),
        .CHAN_A_TX_ACTIVITY_PIN_PU(txpu), .CHAN_A_RX_ACTIVITY_PIN_I(rxp),
        .CHAN_A_RX_ACTIVITY_PIN_O(rxo), .CHAN_A_RX_ACTIVITY_PIN_OE(rxoe),
        .CHAN_A_RX_ACTIVITY_PIN_PU(rxpu), .DPLUS_PULLUP_EN(dpl), .RESET_PIN_N_I(rpin),
        .RESET_PIN_N_O(), .RESET_PIN_N_OE(rpoe), .CORE_RESET(core),
        .USB_CONDITION_OUT_ONE(one), .USB_CONDITION_OUT_TWO(two));
    board_model board_model_inst (.clk(clk), .go(go), .plen(plen), .rst_oe(rpoe),
        .tx_o(txo), .tx_oe(txoe), .tx_pu(txpu), .rx_o(rxo), .rx_oe(rxoe),
        .rx_pu(rxpu), .rst_pin(rpin), .tx_pad(txp), .rx_pad(rxp));
    // Compare and count; four-state so unknowns fail
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
        end
    endtask : chk
    // One-cycle write strobe
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    // Read strobe; data stands only in the next cycle
    task automatic rd_reg(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(rdata, e);
    endtask : rd_reg
    // Let n edges pass, then sample settled outputs
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : end_of_test
    // 10 MHz clock
    initial begin
        clk = 1'b0;
        forever #50 clk = !clk;
    end
    // Watchdog, run needs about 660 cycles
    initial begin
        repeat (6000) @(posedge clk);
        n_mismatch++;
        end_of_test();
    end
    initial begin
        {rst_n, wr, rd, txb, rxb, brst, susp, vsen, go} = '0;
        cfgd = 1'b1;
        addr = '0;
        wdata = '0;
        plen = '0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        tick(1);
        chk({rpoe, rpin, txoe, txpu}, 4'h9);
        tick(160);
        chk(rpin, 1'b1);
        for (int i = 0; i < 5; i++) rd_reg(i[3:0], rv[i]);
        // Status word: pads pulled up, output two idle high, no reset
        rd_reg(4'h5, 8'h74);
        wr_reg(4'h6, 8'hFF);
        rd_reg(4'h6, 8'h00);
        chk({one, two}, 2'h1);
        @(posedge clk) susp <= 1'b1;
        tick(3);
        chk({one, two}, 2'h2);
        // Each condition alone, output one high-true, two low-true
        for (int k = 0; k < 3; k++) begin
            wr_reg(4'h3, 8'h33);
            wr_reg(4'h1, 8'h80 | (8'h01 << k));
            wr_reg(4'h2, 8'h01 << k);
            @(posedge clk);
            {brst, susp, cfgd} <= {k == 0, k == 1, k != 2};
            tick(3);
            chk({one, two}, 2'h2);
            @(posedge clk) {brst, susp, cfgd} <= 3'b001;
            tick(3);
            chk({one, two}, 2'h1);
        end
        wr_reg(4'h3, 8'h32);
        @(posedge clk) cfgd <= 1'b0;
        tick(3);
        chk(one, 1'b0);
        wr_reg(4'h4, 8'h02);
        @(posedge clk) vsen <= 1'b1;
        tick(3);
        chk(dpl, 1'b1);
        @(posedge clk) vsen <= 1'b0;
        tick(3);
        chk(dpl, 1'b0);
        wr_reg(4'h0, 8'h07);
        tick(3);
        chk({txoe, rxoe, txo, rxo}, 4'hF);
        @(posedge clk) {txb, rxb} <= 2'h3;
        tick(50);
        // Far short of a half period, so no toggle may show yet
        chk({txoe, rxoe, txo, rxo}, 4'hF);
        @(posedge clk) {txb, rxb} <= 2'h0;
        tick(4);
        chk({txo, rxo, txp, rxp}, 4'hF);
        wr_reg(4'h0, 8'h00);
        tick(3);
        chk({txoe, rxoe, txpu, rxpu}, 4'h0);
        wr_reg(4'h4, 8'h01);
        tick(1);
        chk({rpoe, rpin, core}, 3'h5);
        tick(160);
        chk(rpoe, 1'b0);
        @(posedge clk);
        plen <= 16'd160;
        go <= 1'b1;
        @(posedge clk) go <= 1'b0;
        tick(156);
        chk(core, 1'b1);
        tick(20);
        // Released pin ends the external reset
        chk(core, 1'b0);
        end_of_test();
    end
endmodule : usb_status_pins_test
